//--- asc_device.sv
// Notes on behaviour
// - interrupt only when config bit 7 set
// - config bit 6 repeats sequences continuously
// - offset compensation needs channel 15 selected
// - config bit 4 holds converter in reset
// - prescaler code divides bus clock
// - software sets soft reset during clock changes
// - status bit 7 done, cleared by read
// - status bit 6 current limit, 5:4 zero
// - status 3:0 active channel, resets ones
// - visit order 15, 0, 1 .. 14
// - select bit includes its channel
// - select write aborts sequence, high byte write restarts it
// - writing zero select stops conversion
// - select write clears all done flags
// - only high byte write starts conversion
// - single channel is one-bit selection
// - done flags read-only, bit 13 zero
// - registers decoded at 0x200 and 0x300
// - word or high byte result read clears its done flag
// - byte read of done flags is live
`timescale 1ns/1ps
module asc_device (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	// die link
	asc_link_if.dev LINK,
	// converter front end
	input wire logic [9:0] ANALOG_RESULT_IN,
	input wire logic CURRENT_LIMIT_IN,
	// converter control
	output logic [3:0] MUX_CHANNEL_OUT,
	output logic CONVERTING_OUT,
	output logic OFFSET_COMP_OUT,
	output logic IRQ_OUT
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] cfg_q, cfg_d;
	logic [15:0] sel_q, sel_d;
	logic [15:0] done_q, done_d;
	logic scf_q, scf_d;
	logic clim_q, clim_d;
	logic [3:0] cnt_q, cnt_d;
	asc_pkg::asc_state_type st_q, st_d;
	logic [4:0] tmr_q, tmr_d;
	logic [9:0] res_q [0:15];
	logic [9:0] res_d [0:15];
	logic [9:0] ofs_q, ofs_d;
	logic ofs_valid_q, ofs_valid_d;
	logic [7:0] latch_q, latch_d;
	logic ack_q, ack_d;
	logic [15:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic conv_q, conv_d;

	logic tick;
	logic take, hit, rd, wr, fin;
	logic [7:0] off;
	logic res_hit;
	logic [3:0] res_ch;
	logic [7:0] diff;
	logic sel_wr_hi, sel_wr_lo;
	logic [15:0] new_sel;
	logic [11:0] comp;
	logic [9:0] sample;

	// ----------------------------------------
	// converter clock
	// ----------------------------------------
	asc_clk_div u_div (
		.clock_in(CLOCK_IN),
		.reset_in(RESET_IN || cfg_q[asc_pkg::CFG_SOFT_RESET]),
		.code_in(cfg_q[2:0]),
		.tick_out(tick)
	);

	// ----------------------------------------
	// register read view
	// ----------------------------------------
	function automatic logic [7:0] byte_of(input logic [7:0] a);
		logic [7:0] d;
		logic [3:0] ch;
		d = a - asc_pkg::OFS_RESULT_FIRST;
		ch = d[4:1];
		case (a)
			asc_pkg::OFS_CONFIG: byte_of = cfg_q;
			asc_pkg::OFS_STATUS: byte_of = {scf_q, clim_q, 2'b00, cnt_q};
			asc_pkg::OFS_SELECT_HI: byte_of = sel_q[15:8];
			asc_pkg::OFS_SELECT_LO: byte_of = sel_q[7:0];
			asc_pkg::OFS_DONE_HI: byte_of = done_q[15:8] & asc_pkg::DONE_MASK[15:8];
			asc_pkg::OFS_DONE_LO: byte_of = done_q[7:0];
			default: begin
				if (a >= asc_pkg::OFS_RESULT_FIRST && a <= asc_pkg::OFS_RESULT_LAST) begin
					byte_of = a[0] ? {res_q[ch][1:0], 6'h00} : res_q[ch][9:2];
				end else begin
					byte_of = 8'h00;
				end
			end
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		sel_d = sel_q;
		done_d = done_q;
		scf_d = scf_q;
		clim_d = CURRENT_LIMIT_IN;
		cnt_d = cnt_q;
		st_d = st_q;
		tmr_d = tmr_q;
		res_d = res_q;
		ofs_d = ofs_q;
		ofs_valid_d = ofs_valid_q;
		latch_d = latch_q;
		rdata_d = rdata_q;
		fin = 1'b0;

		take = LINK.req && !ack_q;
		off = LINK.addr[7:0];
		hit = take && (LINK.addr[9:8] == asc_pkg::BASE_BLOCKING
			|| LINK.addr[9:8] == asc_pkg::BASE_NONBLOCKING);
		rd = hit && !LINK.wr;
		wr = hit && LINK.wr;
		ack_d = take;
		diff = off - asc_pkg::OFS_RESULT_FIRST;
		res_ch = diff[4:1];
		res_hit = off >= asc_pkg::OFS_RESULT_FIRST && off <= asc_pkg::OFS_RESULT_LAST;

		// reads and their side effects
		if (take) begin
			rdata_d = 16'h0000;
		end
		if (rd) begin
			if (LINK.word) begin
				rdata_d = {byte_of(off), byte_of(off | 8'h01)};
			end else if (res_hit && !off[0]) begin
				rdata_d = {8'h00, asc_pkg::DONE_MASK[res_ch] ? latch_q : 8'h00};
			end else begin
				rdata_d = {8'h00, byte_of(off)};
			end
			if (off == asc_pkg::OFS_STATUS || (LINK.word && off == asc_pkg::OFS_CONFIG)) begin
				scf_d = 1'b0;
			end
			if (res_hit) begin
				if (LINK.word || !off[0]) begin
					done_d[res_ch] = 1'b0;
				end else begin
					latch_d = res_q[res_ch][9:2];
				end
			end
		end

		// writes
		if (wr && off == asc_pkg::OFS_CONFIG) begin
			cfg_d = (LINK.word ? LINK.wdata[15:8] : LINK.wdata[7:0]) & asc_pkg::CONFIG_WRITABLE;
		end
		sel_wr_hi = wr && off == asc_pkg::OFS_SELECT_HI;
		sel_wr_lo = wr && ((off == asc_pkg::OFS_SELECT_HI && LINK.word)
			|| (off == asc_pkg::OFS_SELECT_LO && !LINK.word));
		new_sel = sel_q;
		if (sel_wr_hi) begin
			new_sel[15:8] = LINK.word ? LINK.wdata[15:8] : LINK.wdata[7:0];
		end
		if (sel_wr_lo) begin
			new_sel[7:0] = LINK.wdata[7:0];
		end

		// offset-compensated sample
		comp = {2'b00, ANALOG_RESULT_IN} + {2'b00, asc_pkg::CAL_REF_LSB} - {2'b00, ofs_q};
		if (!cfg_q[asc_pkg::CFG_OFFSET_COMP] || !ofs_valid_q || cnt_q == asc_pkg::CH_FIRST) begin
			sample = ANALOG_RESULT_IN;
		end else if (comp[11]) begin
			sample = 10'h000;
		end else if (comp[10]) begin
			sample = asc_pkg::RESULT_MAX;
		end else begin
			sample = comp[9:0];
		end

		if (sel_wr_hi || sel_wr_lo) begin
			sel_d = new_sel;
			done_d = asc_pkg::DONE_RESET;
			ofs_valid_d = 1'b0;
			st_d = asc_pkg::ST_IDLE;
			if (sel_wr_hi && new_sel != asc_pkg::SELECT_RESET) begin
				st_d = asc_pkg::ST_SCAN;
				cnt_d = asc_pkg::CH_FIRST;
				tmr_d = 5'h00;
			end
		end else if (tick) begin
			case (st_q)
				asc_pkg::ST_IDLE: begin
				end
				asc_pkg::ST_SCAN: begin
					if (sel_q[cnt_q]) begin
						st_d = asc_pkg::ST_CONV;
						tmr_d = asc_pkg::SAMPLE_TICKS + asc_pkg::CONVERT_TICKS - 5'h01;
					end else if (cnt_q == asc_pkg::CH_LAST) begin
						fin = 1'b1;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				asc_pkg::ST_CONV: begin
					if (tmr_q == 5'h00) begin
						res_d[cnt_q] = asc_pkg::DONE_MASK[cnt_q] ? sample : 10'h000;
						done_d = done_d | (asc_pkg::DONE_MASK & (16'h0001 << cnt_q));
						if (cnt_q == asc_pkg::CH_FIRST) begin
							ofs_d = ANALOG_RESULT_IN;
							ofs_valid_d = 1'b1;
						end
						if (cnt_q == asc_pkg::CH_LAST) begin
							fin = 1'b1;
						end else begin
							st_d = asc_pkg::ST_GAP;
							tmr_d = asc_pkg::GAP_TICKS - 5'h01;
							cnt_d = cnt_q + 4'h1;
						end
					end else begin
						tmr_d = tmr_q - 5'h01;
					end
				end
				asc_pkg::ST_GAP: begin
					if (tmr_q == 5'h00) begin
						st_d = asc_pkg::ST_SCAN;
					end else begin
						tmr_d = tmr_q - 5'h01;
					end
				end
				default: st_d = asc_pkg::ST_IDLE;
			endcase
		end

		if (fin) begin
			scf_d = 1'b1;
			if (cfg_q[asc_pkg::CFG_CONTINUOUS]) begin
				st_d = asc_pkg::ST_SCAN;
				cnt_d = asc_pkg::CH_FIRST;
				tmr_d = 5'h00;
			end else begin
				st_d = asc_pkg::ST_IDLE;
			end
		end

		if (cfg_q[asc_pkg::CFG_SOFT_RESET]) begin
			sel_d = asc_pkg::SELECT_RESET;
			done_d = asc_pkg::DONE_RESET;
			scf_d = 1'b0;
			cnt_d = asc_pkg::COUNTER_RESET;
			st_d = asc_pkg::ST_IDLE;
			tmr_d = 5'h00;
			ofs_valid_d = 1'b0;
			latch_d = 8'h00;
			for (int i = 0; i < 16; i++) begin
				res_d[i] = 10'h000;
			end
		end

		irq_d = scf_d && cfg_d[asc_pkg::CFG_IRQ_EN];
		conv_d = st_d == asc_pkg::ST_CONV;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			cfg_q <= asc_pkg::CONFIG_RESET;
			sel_q <= asc_pkg::SELECT_RESET;
			done_q <= asc_pkg::DONE_RESET;
			scf_q <= 1'b0;
			clim_q <= 1'b0;
			cnt_q <= asc_pkg::COUNTER_RESET;
			st_q <= asc_pkg::ST_IDLE;
			tmr_q <= 5'h00;
			for (int i = 0; i < 16; i++) begin
				res_q[i] <= 10'h000;
			end
			ofs_q <= 10'h000;
			ofs_valid_q <= 1'b0;
			latch_q <= 8'h00;
			ack_q <= 1'b0;
			rdata_q <= 16'h0000;
			irq_q <= 1'b0;
			conv_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			sel_q <= sel_d;
			done_q <= done_d;
			scf_q <= scf_d;
			clim_q <= clim_d;
			cnt_q <= cnt_d;
			st_q <= st_d;
			tmr_q <= tmr_d;
			res_q <= res_d;
			ofs_q <= ofs_d;
			ofs_valid_q <= ofs_valid_d;
			latch_q <= latch_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			conv_q <= conv_d;
		end
	end

	assign LINK.ack = ack_q;
	assign LINK.rdata = rdata_q;
	assign MUX_CHANNEL_OUT = cnt_q;
	assign CONVERTING_OUT = conv_q;
	assign OFFSET_COMP_OUT = cfg_q[asc_pkg::CFG_OFFSET_COMP];
	assign IRQ_OUT = irq_q;
endmodule

//--- asc_pkg.sv
package asc_pkg;

	// ----------------------------------------
	// link address decode
	// ----------------------------------------
	localparam logic [1:0] BASE_BLOCKING = 2'h2;
	localparam logic [1:0] BASE_NONBLOCKING = 2'h3;
	localparam logic [7:0] OFS_CONFIG = 8'h80;
	localparam logic [7:0] OFS_STATUS = 8'h81;
	localparam logic [7:0] OFS_SELECT_HI = 8'h82;
	localparam logic [7:0] OFS_SELECT_LO = 8'h83;
	localparam logic [7:0] OFS_DONE_HI = 8'h84;
	localparam logic [7:0] OFS_DONE_LO = 8'h85;
	localparam logic [7:0] OFS_RESULT_FIRST = 8'h86;
	localparam logic [7:0] OFS_RESULT_LAST = 8'ha5;

	// ----------------------------------------
	// configuration fields and reset values
	// ----------------------------------------
	localparam int CFG_IRQ_EN = 7;
	localparam int CFG_CONTINUOUS = 6;
	localparam int CFG_OFFSET_COMP = 5;
	localparam int CFG_SOFT_RESET = 4;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] CONFIG_WRITABLE = 8'hf7;
	localparam logic [3:0] COUNTER_RESET = 4'hf;
	localparam logic [15:0] SELECT_RESET = 16'h0000;
	localparam logic [15:0] DONE_RESET = 16'h0000;
	localparam logic [15:0] DONE_MASK = 16'hdfff;

	// ----------------------------------------
	// sequencing and timing in converter clocks
	// ----------------------------------------
	localparam logic [3:0] CH_FIRST = 4'hf;
	localparam logic [3:0] CH_LAST = 4'he;
	localparam logic [4:0] SAMPLE_TICKS = 5'h09;
	localparam logic [4:0] CONVERT_TICKS = 5'h12;
	localparam logic [4:0] GAP_TICKS = 5'h04;
	localparam logic [9:0] CAL_REF_LSB = 10'h008;
	localparam logic [9:0] RESULT_MAX = 10'h3ff;

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_CONV, ST_GAP} asc_state_type;

	function automatic logic [3:0] divisor(input logic [2:0] code);
		case (code)
			3'h0: divisor = 4'ha;
			3'h1: divisor = 4'h8;
			3'h2: divisor = 4'h6;
			3'h3: divisor = 4'h4;
			3'h4: divisor = 4'h2;
			default: divisor = 4'h1;
		endcase
	endfunction

	// ----------------------------------------
	// controller apb map
	// ----------------------------------------
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam int CMD_WRITE_BIT = 27;
	localparam int CMD_WORD_BIT = 26;
	localparam int CMD_ADDR_LSB = 16;
	localparam int STATUS_BUSY_BIT = 16;

endpackage

//--- asc_link_if.sv
`timescale 1ns/1ps
interface asc_link_if;
	logic req;
	logic wr;
	logic word;
	logic [9:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic ack;

	modport dev (
		input req,
		input wr,
		input word,
		input addr,
		input wdata,
		output rdata,
		output ack
	);

	modport host (
		output req,
		output wr,
		output word,
		output addr,
		output wdata,
		input rdata,
		input ack
	);
endinterface

//--- asc_clk_div.sv
`timescale 1ns/1ps
module asc_clk_div (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// divider select
	input wire logic [2:0] code_in,
	// one tick per converter clock
	output logic tick_out
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic tick_q;
	logic tick_d;
	logic last;

	always_comb begin
		last = (cnt_q >= (asc_pkg::divisor(code_in) - 4'h1));
		cnt_d = last ? 4'h0 : cnt_q + 4'h1;
		tick_d = last;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cnt_q <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;
endmodule

//--- asc_host.sv
`timescale 1ns/1ps
module asc_host (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// die link
	asc_link_if.host LINK
);
	logic req_q, req_d;
	logic wr_q, wr_d;
	logic word_q, word_d;
	logic [9:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] rdata_q, rdata_d;
	logic pready_q, pready_d;
	logic perr_q, perr_d;
	logic [31:0] prdata_q, prdata_d;
	logic access;

	// ----------------------------------------
	// command and link sequencing
	// ----------------------------------------
	always_comb begin
		req_d = req_q;
		wr_d = wr_q;
		word_d = word_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		prdata_d = prdata_q;
		access = PSEL_IN && PENABLE_IN && !pready_q;
		pready_d = access;
		perr_d = access && PADDR_IN != asc_pkg::APB_CMD && PADDR_IN != asc_pkg::APB_STATUS;
		if (req_q && LINK.ack) begin
			req_d = 1'b0;
			rdata_d = LINK.rdata;
		end
		if (access && PWRITE_IN && PADDR_IN == asc_pkg::APB_CMD && !req_q) begin
			req_d = 1'b1;
			wr_d = PWDATA_IN[asc_pkg::CMD_WRITE_BIT];
			word_d = PWDATA_IN[asc_pkg::CMD_WORD_BIT];
			addr_d = PWDATA_IN[asc_pkg::CMD_ADDR_LSB +: 10];
			wdata_d = PWDATA_IN[15:0];
		end
		if (access && !PWRITE_IN) begin
			case (PADDR_IN)
				asc_pkg::APB_CMD: prdata_d = {4'h0, wr_q, word_q, addr_q, wdata_q};
				asc_pkg::APB_STATUS: prdata_d = {15'h0000, req_q, rdata_q};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			req_q <= 1'b0;
			wr_q <= 1'b0;
			word_q <= 1'b0;
			addr_q <= 10'h000;
			wdata_q <= 16'h0000;
			rdata_q <= 16'h0000;
			pready_q <= 1'b0;
			perr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			req_q <= req_d;
			wr_q <= wr_d;
			word_q <= word_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			pready_q <= pready_d;
			perr_q <= perr_d;
			prdata_q <= prdata_d;
		end
	end

	assign LINK.req = req_q;
	assign LINK.wr = wr_q;
	assign LINK.word = word_q;
	assign LINK.addr = addr_q;
	assign LINK.wdata = wdata_q;
	assign PRDATA_OUT = prdata_q;
	assign PREADY_OUT = pready_q;
	assign PSLVERR_OUT = perr_q;
endmodule

//--- asc_link_assertions.sv
`timescale 1ns/1ps
module asc_link_assertions (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	// link signals
	input wire logic req,
	input wire logic wr,
	input wire logic word,
	input wire logic [9:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ack
);
	// ----------------------------------------
	// shadow of the configuration register
	// ----------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic take;
	logic rd;
	assign take = req && !ack;
	assign rd = take && !wr && addr[9];
	always_comb begin
		cfg_d = cfg_q;
		if (take && wr && addr[9] && addr[7:0] == asc_pkg::OFS_CONFIG) begin
			cfg_d = word ? wdata[15:8] : wdata[7:0];
		end
	end
	always_ff @(posedge CLOCK_IN) begin
		cfg_q <= RESET_IN ? asc_pkg::CONFIG_RESET : cfg_d;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RESET_IN);
	property p_ack_pulse; ack |=> !ack; endproperty
	property p_take_ack; take |=> ack; endproperty
	property p_rdata_hold; !take |=> $stable(rdata); endproperty
	property p_status; rd && !word && addr[7:0] == asc_pkg::OFS_STATUS |=> ack && rdata[5:4] == 2'h0; endproperty
	property p_done13; rd && word && addr[7:0] == asc_pkg::OFS_DONE_HI |=> rdata[13] == 1'b0; endproperty
	property p_res13; rd && addr[7:1] == 7'h50 |=> rdata == 16'h0000; endproperty
	property p_unmapped; take && !addr[9] |=> ack && rdata == 16'h0000; endproperty
	property p_cfg; rd && !word && addr[7:0] == asc_pkg::OFS_CONFIG |=> rdata[7:0] == (cfg_q & asc_pkg::CONFIG_WRITABLE);
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	a_take_ack: assert property (p_take_ack)
		else $error("request not answered");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without request");
	a_status: assert property (p_status)
		else $error("status bits 5 and 4 not zero");
	a_done13: assert property (p_done13)
		else $error("done flag 13 not zero");
	a_res13: assert property (p_res13)
		else $error("channel 13 result not zero");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_cfg: assert property (p_cfg)
		else $error("config read back wrong");
	c_select: cover property (take && wr && addr[7:0] == asc_pkg::OFS_SELECT_HI);
	c_status: cover property (rd && addr[7:0] == asc_pkg::OFS_STATUS);
	c_unmapped: cover property (take && !addr[9]);
endmodule

//--- test_adc_sequencer_control.sv
`timescale 1ns/1ps
module test_adc_sequencer_control;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic err;
	logic [9:0] analog = 10'h2a5;
	logic limit = 1'b0;
	logic [3:0] mux;
	logic conv;
	logic ocomp;
	logic irq;
	logic [15:0] r;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	asc_link_if asc_link_if_i ();
	asc_host asc_host_i (.CLOCK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.LINK(asc_link_if_i));
	asc_device asc_device_i (.CLOCK_IN(clk), .RESET_IN(rst), .LINK(asc_link_if_i), .ANALOG_RESULT_IN(analog),
		.CURRENT_LIMIT_IN(limit), .MUX_CHANNEL_OUT(mux), .CONVERTING_OUT(conv), .OFFSET_COMP_OUT(ocomp),
		.IRQ_OUT(irq));
	asc_link_assertions asc_link_assertions_i (.CLOCK_IN(clk), .RESET_IN(rst), .req(asc_link_if_i.req),
		.wr(asc_link_if_i.wr), .word(asc_link_if_i.word), .addr(asc_link_if_i.addr), .wdata(asc_link_if_i.wdata),
		.rdata(asc_link_if_i.rdata), .ack(asc_link_if_i.ack));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task link(input logic w, input logic wd, input logic [9:0] a, input logic [15:0] d);
		logic [31:0] s;
		apb(1'b1, asc_pkg::APB_CMD, {4'h0, w, wd, a, d}, s);
		do apb(1'b0, asc_pkg::APB_STATUS, 32'h0, s); while (s[asc_pkg::STATUS_BUSY_BIT] !== 1'b0);
		r = s[15:0];
	endtask
	task wait_conv(input logic lvl);
		repeat (400) begin
			@(negedge clk);
			if (conv === lvl) break;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset();
		link(0, 0, 10'h281, 16'h0);
		chk("status", 16'h000f, r);
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h0000, r);
		@(negedge clk);
		chk("mux", 16'h000f, 16'(mux));
		@(posedge clk);
		limit <= 1'b1;
		link(0, 0, 10'h281, 16'h0);
		chk("status", 16'h004f, r);
		limit <= 1'b0;
		$display("test reset done");
	endtask
	task t_config();
		logic [31:0] s;
		for (int c = 0; c < 8; c++) begin
			link(1, 0, 10'h380, 16'h0020 + 16'(c));
			link(0, 0, 10'h280, 16'h0);
			chk("config", 16'h0020 + 16'(c), r);
		end
		@(negedge clk);
		chk("offset comp", 16'h0001, 16'(ocomp));
		link(1, 0, 10'h280, 16'h00ff);
		link(0, 0, 10'h380, 16'h0);
		chk("config", 16'(asc_pkg::CONFIG_WRITABLE), r);
		link(0, 1, 10'h180, 16'h0);
		chk("unmapped", 16'h0000, r);
		apb(1'b0, 8'h08, 32'h0, s);
		chk("apb error", 16'h0001, 16'(err));
		chk("apb unmapped", 16'h0000, s[15:0]);
		apb(1'b0, asc_pkg::APB_STATUS, 32'h0, s);
		chk("apb error", 16'h0000, 16'(err));
		$display("test config done");
	endtask
	task t_single();
		int n;
		link(1, 0, 10'h280, 16'h0083);
		link(1, 1, 10'h282, 16'h0400);
		wait_conv(1'b1);
		chk("mux", 16'h000a, 16'(mux));
		n = 0;
		while (conv === 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("convert cycles", 16'h006c, 16'(n));
		repeat (200) begin
			@(negedge clk);
			if (irq === 1'b1) break;
		end
		chk("irq", 16'h0001, 16'(irq));
		link(1, 0, 10'h280, 16'h0003);
		@(negedge clk);
		chk("irq", 16'h0000, 16'(irq));
		link(1, 0, 10'h280, 16'h0083);
		@(negedge clk);
		chk("irq", 16'h0001, 16'(irq));
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h0400, r);
		link(0, 1, 10'h29a, 16'h0);
		chk("result", 16'ha940, r);
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h0000, r);
		link(0, 0, 10'h281, 16'h0);
		chk("status", 16'h0080, r & 16'h00b0);
		@(negedge clk);
		chk("irq", 16'h0000, 16'(irq));
		link(0, 0, 10'h281, 16'h0);
		chk("status", 16'h0000, r & 16'h0080);
		$display("test single done");
	endtask
	task t_bytes();
		link(1, 0, 10'h280, 16'h0005);
		link(1, 0, 10'h283, 16'h0001);
		repeat (60) @(negedge clk);
		chk("converting", 16'h0000, 16'(conv));
		link(1, 0, 10'h282, 16'h0080);
		wait_conv(1'b1);
		chk("mux", 16'h000f, 16'(mux));
		r = 16'h0;
		repeat (40) if (r[7] !== 1'b1) link(0, 0, 10'h281, 16'h0);
		chk("status", 16'h0080, r & 16'h0080);
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h8001, r);
		link(0, 0, 10'h285, 16'h0);
		chk("done lo", 16'h0001, r);
		link(0, 0, 10'h287, 16'h0);
		link(0, 0, 10'h286, 16'h0);
		chk("result hi", 16'h00a9, r);
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h8000, r);
		link(0, 1, 10'h2a0, 16'h0);
		chk("reserved", 16'h0000, r);
		link(0, 0, 10'h2a0, 16'h0);
		chk("reserved hi", 16'h0000, r);
		$display("test bytes done");
	endtask
	task t_restart();
		link(1, 0, 10'h280, 16'h0045);
		link(1, 1, 10'h282, 16'h0001);
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h0000, r);
		r = 16'h0;
		repeat (40) if (r[7] !== 1'b1) link(0, 0, 10'h281, 16'h0);
		wait_conv(1'b1);
		chk("converting", 16'h0001, 16'(conv));
		link(1, 1, 10'h282, 16'h0002);
		wait_conv(1'b1);
		chk("mux", 16'h0001, 16'(mux));
		link(1, 1, 10'h282, 16'h0000);
		repeat (100) @(negedge clk);
		chk("converting", 16'h0000, 16'(conv));
		$display("test restart done");
	endtask
	task t_divide();
		int n;
		int divs [0:4];
		divs = '{10, 8, 6, 4, 2};
		for (int c = 0; c < 5; c++) begin
			link(1, 0, 10'h280, 16'h0010 + 16'(c));
			link(1, 0, 10'h280, 16'(c));
			link(1, 1, 10'h282, 16'h0400);
			wait_conv(1'b1);
			n = 0;
			while (conv === 1'b1 && n < 400) begin
				@(negedge clk);
				n++;
			end
			chk("divided cycles", 16'(divs[c] * (asc_pkg::SAMPLE_TICKS + asc_pkg::CONVERT_TICKS)), 16'(n));
		end
		$display("test divide done");
	endtask
	task t_soft();
		link(1, 0, 10'h280, 16'h0025);
		link(1, 1, 10'h282, 16'h8001);
		repeat (100) @(negedge clk);
		link(0, 1, 10'h286, 16'h0);
		chk("compensated", 16'h0200, r);
		link(0, 1, 10'h2a4, 16'h0);
		chk("reference", 16'ha940, r);
		link(1, 0, 10'h280, 16'h0015);
		link(0, 1, 10'h284, 16'h0);
		chk("done flags", 16'h0000, r);
		link(0, 0, 10'h281, 16'h0);
		chk("status", 16'h000f, r);
		link(0, 0, 10'h280, 16'h0);
		chk("config", 16'h0015, r);
		link(1, 0, 10'h280, 16'h0005);
		$display("test soft reset done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_config();
		t_single();
		t_bytes();
		t_restart();
		t_divide();
		t_soft();
		conclude();
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			conclude();
		end
	end
endmodule
